// ---- logic/alarm_pkg.sv ----
// shared constants, encodings and carriers of the status and alarm unit
package alarm_pkg;

   // ****************************************************************
   // widths
   // ****************************************************************
   localparam int unsigned DATA_W = 14;
   localparam int unsigned ADDR_W = 7;

   // ****************************************************************
   // byte addresses (even address = low byte, odd address = high byte)
   // ****************************************************************
   localparam logic [6:0] ADDR_THRESH_ONE = 7'h20;
   localparam logic [6:0] ADDR_THRESH_TWO = 7'h22;
   localparam logic [6:0] ADDR_CONTROL    = 7'h28;
   localparam logic [6:0] ADDR_CAPTURE    = 7'h38;
   localparam logic [6:0] ADDR_STATUS     = 7'h3c;
   localparam logic [6:0] ADDR_COMMAND    = 7'h3e;

   // ****************************************************************
   // reset values
   // ****************************************************************
   localparam logic [15:0] RST_THRESH  = 16'h0000;
   localparam logic [15:0] RST_CONTROL = 16'h0000;
   localparam logic [15:0] RST_CAPTURE = 16'h327a;
   localparam logic [15:0] RST_STATUS  = 16'h0000;

   // ****************************************************************
   // alarm_control fields
   // ****************************************************************
   localparam int unsigned CTL_SRC_TWO_LSB = 12;
   localparam int unsigned CTL_SRC_ONE_LSB = 8;
   localparam int unsigned CTL_TRIG_TWO    = 6;
   localparam int unsigned CTL_TRIG_ONE    = 4;
   localparam int unsigned CTL_LINE_EN     = 2;
   localparam int unsigned CTL_LINE_POL    = 1;
   localparam int unsigned CTL_LINE_SEL    = 0;

   // threshold, capture configuration and command fields
   localparam int unsigned THR_DIR          = 15;
   localparam int unsigned CAP_SRC_TWO_LSB  = 12;
   localparam int unsigned CAP_SRC_ONE_LSB  = 8;
   localparam int unsigned CMD_FLAG_CLEAR   = 4;

   // ****************************************************************
   // error_flags bit positions
   // ****************************************************************
   localparam int unsigned ST_UNDER     = 0;
   localparam int unsigned ST_OVER      = 1;
   localparam int unsigned ST_FLASH     = 2;
   localparam int unsigned ST_SERIAL    = 3;
   localparam int unsigned ST_SELFTEST  = 5;
   localparam int unsigned ST_ALARM_ONE = 8;
   localparam int unsigned ST_ALARM_TWO = 9;
   localparam int unsigned ST_BUF_FULL  = 12;
   localparam logic [15:0] ST_LATCH_MASK = 16'h132c;
   localparam logic [15:0] ST_USED_MASK  = 16'h132f;

   // ****************************************************************
   // source encoding shared by alarms and capture buffers
   // ****************************************************************
   typedef enum logic [3:0] {
      SRC_NONE   = 4'h0,
      SRC_SUPPLY = 4'h1,
      SRC_X      = 4'h2,
      SRC_Y      = 4'h3,
      SRC_AUX    = 4'h4,
      SRC_TEMP   = 4'h5,
      SRC_RSS    = 4'h8
   } src_e;

   // ****************************************************************
   // carriers
   // ****************************************************************
   typedef struct packed {
      logic [13:0] supply;
      logic [13:0] x;
      logic [13:0] y;
      logic [13:0] aux;
      logic [13:0] temp;
      logic [13:0] rss;
   } chan_s;

   // a claim on one shared digital line
   typedef struct packed {
      logic owns;
      logic drive;
      logic level;
   } line_req_s;

endpackage

// ---- logic/alarm_compare.sv ----
// threshold comparator for one programmable alarm
module alarm_compare (
   input  wire logic [15:0] threshold,
   input  wire logic [13:0] sample,
   input  wire logic        signed_src,
   output logic             hit
);

   logic [13:0] level;
   logic        above;
   logic        below;

   // bit 14 is ignored, bits 13:0 are compared in the source's own coding
   assign level = threshold[13:0];
   assign above = signed_src ? ($signed(sample) > $signed(level)) : (sample > level);
   assign below = signed_src ? ($signed(sample) < $signed(level)) : (sample < level);
   assign hit   = threshold[alarm_pkg::THR_DIR] ? above : below;

endmodule // alarm_compare

// ---- logic/status_alarm_monitor.sv ----
// status flags, programmable alarms, alarm line drive and capture trigger
module status_alarm_monitor (
   input  wire logic                         core_clk,
   input  wire logic                         rst,
   input  wire logic                         reg_wr,
   input  wire logic                         reg_rd,
   input  wire logic [6:0]                   reg_addr,
   input  wire logic [7:0]                   reg_wdata,
   output logic      [15:0]                  reg_rdata,
   input  wire logic                         sample_tick,
   input  wire alarm_pkg::chan_s             chan,
   input  wire logic                         supply_over,
   input  wire logic                         supply_under,
   input  wire logic                         selftest_fail,
   input  wire logic                         serial_fail,
   input  wire logic                         flash_fail,
   input  wire logic                         buffers_full,
   input  wire alarm_pkg::line_req_s [1:0]   gpio_req,
   input  wire alarm_pkg::line_req_s [1:0]   ready_req,
   output logic      [1:0]                   line_out,
   output logic      [1:0]                   line_oe,
   output logic      [1:0]                   alarm_active,
   output logic                              capture_trigger,
   output logic      [13:0]                  capture_data_one,
   output logic      [13:0]                  capture_data_two
);

   // ****************************************************************
   // helpers
   // ****************************************************************
   function automatic logic [15:0] byte_merge(input logic [15:0] cur,
                                             input logic [6:0]  addr,
                                             input logic [7:0]  data);
      byte_merge = addr[0] ? {data, cur[7:0]} : {cur[15:8], data};
   endfunction

   // unknown encodings read as no source
   function automatic logic src_valid(input logic [3:0] code);
      case (code)
         alarm_pkg::SRC_SUPPLY, alarm_pkg::SRC_X, alarm_pkg::SRC_Y,
         alarm_pkg::SRC_AUX, alarm_pkg::SRC_TEMP, alarm_pkg::SRC_RSS: src_valid = 1'b1;
         default: src_valid = 1'b0;
      endcase
   endfunction

   function automatic logic [13:0] chan_pick(input alarm_pkg::chan_s c,
                                             input logic [3:0]       code);
      case (code)
         alarm_pkg::SRC_SUPPLY: chan_pick = c.supply;
         alarm_pkg::SRC_X:      chan_pick = c.x;
         alarm_pkg::SRC_Y:      chan_pick = c.y;
         alarm_pkg::SRC_AUX:    chan_pick = c.aux;
         alarm_pkg::SRC_TEMP:   chan_pick = c.temp;
         alarm_pkg::SRC_RSS:    chan_pick = c.rss;
         default:               chan_pick = 14'h0000;
      endcase
   endfunction

   // accelerations and temperature are two's complement, the rest straight binary
   function automatic logic src_signed(input logic [3:0] code);
      src_signed = (code == alarm_pkg::SRC_X) || (code == alarm_pkg::SRC_Y) ||
                   (code == alarm_pkg::SRC_TEMP);
   endfunction

   // ****************************************************************
   // registers
   // ****************************************************************
   logic [15:0] thresh_one_ff;
   logic [15:0] thresh_two_ff;
   logic [15:0] control_ff;
   logic [15:0] capture_cfg_ff;
   logic [15:0] flags_ff;
   logic [1:0]  alarm_ff;
   logic        trigger_ff;
   logic [13:0] cap_one_ff;
   logic [13:0] cap_two_ff;
   logic [15:0] rdata_ff;
   logic [1:0]  line_out_ff;
   logic [1:0]  line_oe_ff;

   // ****************************************************************
   // byte-wide register writes
   // ****************************************************************
   wire [6:0] word_addr  = {reg_addr[6:1], 1'b0};
   wire       wr_thr_one = reg_wr && (word_addr == alarm_pkg::ADDR_THRESH_ONE);
   wire       wr_thr_two = reg_wr && (word_addr == alarm_pkg::ADDR_THRESH_TWO);
   wire       wr_control = reg_wr && (word_addr == alarm_pkg::ADDR_CONTROL);
   wire       wr_capture = reg_wr && (word_addr == alarm_pkg::ADDR_CAPTURE);
   wire       flag_clear = reg_wr && (reg_addr == alarm_pkg::ADDR_COMMAND) &&
                           reg_wdata[alarm_pkg::CMD_FLAG_CLEAR];

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         thresh_one_ff  <= alarm_pkg::RST_THRESH;
         thresh_two_ff  <= alarm_pkg::RST_THRESH;
         control_ff     <= alarm_pkg::RST_CONTROL;
         capture_cfg_ff <= alarm_pkg::RST_CAPTURE;
      end else begin
         if (wr_thr_one) thresh_one_ff <= byte_merge(thresh_one_ff, reg_addr, reg_wdata);
         if (wr_thr_two) thresh_two_ff <= byte_merge(thresh_two_ff, reg_addr, reg_wdata);
         if (wr_control) control_ff <= byte_merge(control_ff, reg_addr, reg_wdata);
         if (wr_capture) capture_cfg_ff <= byte_merge(capture_cfg_ff, reg_addr, reg_wdata);
      end
   end

   // ****************************************************************
   // alarm evaluation
   // ****************************************************************
   wire [3:0]  src_one  = control_ff[alarm_pkg::CTL_SRC_ONE_LSB +: 4];
   wire [3:0]  src_two  = control_ff[alarm_pkg::CTL_SRC_TWO_LSB +: 4];
   wire [13:0] samp_one = chan_pick(chan, src_one);
   wire [13:0] samp_two = chan_pick(chan, src_two);
   logic       hit_one;
   logic       hit_two;

   alarm_compare u_cmp_one (
      .threshold  (thresh_one_ff),
      .sample     (samp_one),
      .signed_src (src_signed(src_one)),
      .hit        (hit_one)
   );

   alarm_compare u_cmp_two (
      .threshold  (thresh_two_ff),
      .sample     (samp_two),
      .signed_src (src_signed(src_two)),
      .hit        (hit_two)
   );

   // source 0000 or an unknown code keeps the alarm quiet
   wire live_one = src_valid(src_one) && hit_one;
   wire live_two = src_valid(src_two) && hit_two;

   wire fire = sample_tick &&
               ((live_one && control_ff[alarm_pkg::CTL_TRIG_ONE]) ||
                (live_two && control_ff[alarm_pkg::CTL_TRIG_TWO]));

   wire [3:0] cap_src_one = capture_cfg_ff[alarm_pkg::CAP_SRC_ONE_LSB +: 4];
   wire [3:0] cap_src_two = capture_cfg_ff[alarm_pkg::CAP_SRC_TWO_LSB +: 4];

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         alarm_ff   <= 2'h0;
         trigger_ff <= 1'b0;
         cap_one_ff <= 14'h0000;
         cap_two_ff <= 14'h0000;
      end else begin
         trigger_ff <= fire;
         if (sample_tick) begin
            alarm_ff   <= {live_two, live_one};
            cap_one_ff <= chan_pick(chan, cap_src_one);
            cap_two_ff <= chan_pick(chan, cap_src_two);
         end
      end
   end

   // ****************************************************************
   // error flags
   // ****************************************************************
   // a cause seen in the clearing cycle survives the clear
   logic [15:0] flag_set;
   always_comb begin
      flag_set = 16'h0000;
      flag_set[alarm_pkg::ST_FLASH]     = flash_fail;
      flag_set[alarm_pkg::ST_SERIAL]    = serial_fail;
      flag_set[alarm_pkg::ST_SELFTEST]  = selftest_fail;
      flag_set[alarm_pkg::ST_ALARM_ONE] = sample_tick && live_one;
      flag_set[alarm_pkg::ST_ALARM_TWO] = sample_tick && live_two;
      flag_set[alarm_pkg::ST_BUF_FULL]  = buffers_full;
   end

   wire [15:0] kept     = flag_clear ? 16'h0000 : (flags_ff & alarm_pkg::ST_LATCH_MASK);
   wire [15:0] supplies = {14'h0000, supply_over, supply_under};
   wire [15:0] nxt_flags = ((kept | flag_set) & alarm_pkg::ST_LATCH_MASK) | supplies;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         flags_ff <= alarm_pkg::RST_STATUS;
      end else begin
         flags_ff <= nxt_flags;
      end
   end

   // ****************************************************************
   // register reads, one cycle after the strobe
   // ****************************************************************
   logic [15:0] rd_word;
   always_comb begin
      case (word_addr)
         alarm_pkg::ADDR_THRESH_ONE: rd_word = thresh_one_ff;
         alarm_pkg::ADDR_THRESH_TWO: rd_word = thresh_two_ff;
         alarm_pkg::ADDR_CONTROL:    rd_word = control_ff;
         alarm_pkg::ADDR_CAPTURE:    rd_word = capture_cfg_ff;
         alarm_pkg::ADDR_STATUS:     rd_word = flags_ff;
         default:                    rd_word = 16'h0000;
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rdata_ff <= 16'h0000;
      end else if (reg_rd) begin
         rdata_ff <= rd_word;
      end
   end

   // ****************************************************************
   // shared digital lines
   // ****************************************************************
   wire       any_alarm = |alarm_ff;
   wire       alarm_lvl = control_ff[alarm_pkg::CTL_LINE_POL] ? any_alarm : !any_alarm;
   wire [1:0] alarm_own = control_ff[alarm_pkg::CTL_LINE_EN] ?
                          (control_ff[alarm_pkg::CTL_LINE_SEL] ? 2'h2 : 2'h1) : 2'h0;

   logic [1:0] nxt_line_out;
   logic [1:0] nxt_line_oe;
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         if (gpio_req[i].owns) begin
            nxt_line_out[i] = gpio_req[i].level;
            nxt_line_oe[i]  = gpio_req[i].drive;
         end else if (ready_req[i].owns) begin
            nxt_line_out[i] = ready_req[i].level;
            nxt_line_oe[i]  = 1'b1;
         end else if (alarm_own[i]) begin
            nxt_line_out[i] = alarm_lvl;
            nxt_line_oe[i]  = 1'b1;
         end else begin
            nxt_line_out[i] = 1'b0;
            nxt_line_oe[i]  = 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         line_out_ff <= 2'h0;
         line_oe_ff  <= 2'h0;
      end else begin
         line_out_ff <= nxt_line_out;
         line_oe_ff  <= nxt_line_oe;
      end
   end

   assign reg_rdata        = rdata_ff;
   assign line_out         = line_out_ff;
   assign line_oe          = line_oe_ff;
   assign alarm_active     = alarm_ff;
   assign capture_trigger  = trigger_ff;
   assign capture_data_one = cap_one_ff;
   assign capture_data_two = cap_two_ff;

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   sequence clear_seq;
      flag_clear && !flash_fail && !serial_fail && !selftest_fail && !buffers_full;
   endsequence

   sequence quiet_tick;
      !sample_tick;
   endsequence

   AST_SUPPLY_FOLLOW: assert property (
      ##1 (flags_ff[1:0] == $past({supply_over, supply_under})))
      else $error("supply flags do not follow the supply limits");

   AST_CLEAR_ALL: assert property (
      clear_seq ##0 quiet_tick |=> ((flags_ff & alarm_pkg::ST_LATCH_MASK) == 16'h0000))
      else $error("flag clear left a latched flag set");

   AST_FLAG_HOLDS: assert property (
      flags_ff[alarm_pkg::ST_SERIAL] && !flag_clear |=> flags_ff[alarm_pkg::ST_SERIAL])
      else $error("latched flag dropped without a clear");

   AST_RESET_AGAIN: assert property (
      flag_clear && sample_tick && live_one |=> flags_ff[alarm_pkg::ST_ALARM_ONE])
      else $error("persisting alarm did not set its flag again");

   AST_UNUSED_ZERO: assert property (
      (flags_ff & ~alarm_pkg::ST_USED_MASK) == 16'h0000)
      else $error("unused status bit is set");

   AST_SRC_OFF: assert property (
      sample_tick && (src_one == 4'h0) |=> !alarm_ff[0])
      else $error("disabled alarm one became active");

   AST_TRIG_ARMED: assert property (
      capture_trigger |-> $past(control_ff[alarm_pkg::CTL_TRIG_ONE] ||
                                control_ff[alarm_pkg::CTL_TRIG_TWO]))
      else $error("capture started by an unarmed alarm");

   AST_LINE_OFF: assert property (
      !control_ff[alarm_pkg::CTL_LINE_EN] && !gpio_req[0].owns && !ready_req[0].owns
      |=> !line_oe[0])
      else $error("line one driven with alarm output off");

   AST_POLARITY: assert property (
      control_ff[alarm_pkg::CTL_LINE_EN] && !control_ff[alarm_pkg::CTL_LINE_SEL] &&
      !gpio_req[0].owns && !ready_req[0].owns && $stable(control_ff)
      |=> line_oe[0] && (line_out[0] == ($past(control_ff[alarm_pkg::CTL_LINE_POL]) ~^
                                         $past(any_alarm))))
      else $error("alarm line level does not match the polarity");

   // the line registers what was set up one cycle earlier, so a late write cannot count
   AST_LINE_SELECT: assert property (
      control_ff[alarm_pkg::CTL_LINE_EN] && control_ff[alarm_pkg::CTL_LINE_SEL] &&
      !gpio_req[1].owns && !ready_req[1].owns |=> line_oe[1])
      else $error("selected alarm line two is not driven");

   AST_CAPTURE_PICK: assert property (
      sample_tick && (cap_src_one == alarm_pkg::SRC_X) |=> (capture_data_one == $past(chan.x)))
      else $error("capture buffer one did not record the selected channel");

   AST_GPIO_WINS: assert property (
      gpio_req[1].owns |=> (line_oe[1] == $past(gpio_req[1].drive)) &&
                           (line_out[1] == $past(gpio_req[1].level)))
      else $error("general purpose claim lost its line");

endmodule // status_alarm_monitor

// ---- verif/host_model.sv ----
// host processor model that drives the byte-wide register port
module host_model (
   input  wire logic        core_clk,
   output logic             reg_wr,
   output logic             reg_rd,
   output logic      [6:0]  reg_addr,
   output logic      [7:0]  reg_wdata,
   input  wire logic [15:0] reg_rdata
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = 7'h00;
      reg_wdata = 8'h00;
   end

   // ****************************************************************
   // bus cycles
   // ****************************************************************
   // idle address and data show the inverse of the last value, so a design
   // that samples them outside a strobe sees garbage, not a stale match
   task automatic write_byte(input logic [6:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr    <= 1'b0;
      reg_addr  <= ~a;
      reg_wdata <= ~d;
   endtask

   task automatic read_word(input logic [6:0] a, output logic [15:0] d);
      @(posedge core_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd   <= 1'b0;
      reg_addr <= ~a;
      @(negedge core_clk);
      d = reg_rdata;
   endtask
endmodule // host_model

// ---- verif/status_alarm_monitor_bench.sv ----
// self-checking bench of the status flag and alarm unit
module status_alarm_monitor_bench;
   timeunit 1ns;
   timeprecision 1ps;

   logic                       core_clk = 1'b0;
   logic                       rst      = 1'b1;
   logic                       tick     = 1'b0;
   logic                       s_over   = 1'b0;
   logic                       s_under  = 1'b0;
   logic [3:0]                 causes   = 4'h0;
   alarm_pkg::chan_s           chan     = '0;
   alarm_pkg::line_req_s [1:0] gpio_req = '0;
   alarm_pkg::line_req_s [1:0] rdy_req  = '0;
   logic                       reg_wr;
   logic                       reg_rd;
   logic [6:0]                 reg_addr;
   logic [7:0]                 reg_wdata;
   logic [15:0]                reg_rdata;
   logic [1:0]                 line_out;
   logic [1:0]                 line_oe;
   logic [1:0]                 alarm_active;
   logic                       cap_trig;
   logic [13:0]                cap_one;
   logic [13:0]                cap_two;
   logic [15:0]                rd;
   logic [3:0]                 codes [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'h6, 4'h0};
   int                         fails      = 0;
   int                         num_checks = 0;

   always #12.5 core_clk = ~core_clk;

   host_model HOST (.core_clk(core_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
                    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

   status_alarm_monitor DUT (.core_clk(core_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sample_tick(tick),
      .chan(chan), .supply_over(s_over), .supply_under(s_under), .selftest_fail(causes[2]),
      .serial_fail(causes[1]), .flash_fail(causes[0]), .buffers_full(causes[3]),
      .gpio_req(gpio_req), .ready_req(rdy_req), .line_out(line_out), .line_oe(line_oe),
      .alarm_active(alarm_active), .capture_trigger(cap_trig),
      .capture_data_one(cap_one), .capture_data_two(cap_two));

   // ****************************************************************
   // helpers
   // ****************************************************************
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic rchk(input logic [6:0] a, input logic [15:0] exp);
      HOST.read_word(a, rd);
      chk(rd, exp);
   endtask

   // alarm outputs are looked at in the cycle right after the tick edge
   task automatic tick1;
      @(posedge core_clk);
      tick <= 1'b1;
      @(posedge core_clk);
      tick <= 1'b0;
      @(negedge core_clk);
   endtask

   task automatic settle;
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
   endtask

   function automatic alarm_pkg::chan_s mk(input logic [3:0] c, input logic [13:0] v);
      mk = '0;
      case (c)
         4'h1: mk.supply = v;
         4'h2: mk.x      = v;
         4'h3: mk.y      = v;
         4'h4: mk.aux    = v;
         4'h5: mk.temp   = v;
         4'h8: mk.rss    = v;
         default: mk     = '0;
      endcase
   endfunction

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // ****************************************************************
   // tests
   // ****************************************************************
   initial begin
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      rchk(alarm_pkg::ADDR_THRESH_ONE, alarm_pkg::RST_THRESH);
      rchk(alarm_pkg::ADDR_THRESH_TWO, alarm_pkg::RST_THRESH);
      rchk(alarm_pkg::ADDR_CONTROL, alarm_pkg::RST_CONTROL);
      rchk(alarm_pkg::ADDR_CAPTURE, alarm_pkg::RST_CAPTURE);
      HOST.write_byte(7'h3c, 8'hff);
      HOST.write_byte(7'h3d, 8'hff);
      rchk(alarm_pkg::ADDR_STATUS, 16'h0000);
      HOST.write_byte(7'h10, 8'h5a);
      rchk(7'h10, 16'h0000);
      HOST.write_byte(7'h29, 8'h23);
      rchk(7'h28, 16'h2300);
      HOST.write_byte(7'h28, 8'h57);
      rchk(7'h29, 16'h2357);
      // latched causes, then supply levels that clear themselves
      @(posedge core_clk) causes <= 4'hf;
      @(posedge core_clk) causes <= 4'h0;
      s_over <= 1'b1;
      rchk(alarm_pkg::ADDR_STATUS, 16'h102e);
      @(posedge core_clk) s_over <= 1'b0;
      s_under <= 1'b1;
      rchk(alarm_pkg::ADDR_STATUS, 16'h102d);
      @(posedge core_clk) s_under <= 1'b0;
      rchk(alarm_pkg::ADDR_STATUS, 16'h102c);
      HOST.write_byte(7'h3e, 8'hef);
      rchk(alarm_pkg::ADDR_STATUS, 16'h102c);
      HOST.write_byte(7'h3e, 8'h10);
      rchk(alarm_pkg::ADDR_STATUS, 16'h0000);
      @(posedge core_clk) causes <= 4'h2;
      HOST.write_byte(7'h3e, 8'h10);
      rchk(alarm_pkg::ADDR_STATUS, 16'h0008);
      @(posedge core_clk) causes <= 4'h0;
      HOST.write_byte(7'h3e, 8'h10);
      // alarm one on x above 432, armed, line two active high
      HOST.write_byte(7'h21, 8'h81);
      HOST.write_byte(7'h20, 8'hb0);
      HOST.write_byte(7'h29, 8'h02);
      HOST.write_byte(7'h28, 8'h17);
      @(posedge core_clk) chan <= mk(4'h2, 14'd500);
      tick1;
      chk(16'(alarm_active), 16'h0001);
      chk(16'(cap_trig), 16'h0001);
      @(posedge core_clk);
      @(negedge core_clk);
      chk(16'(cap_trig), 16'h0000);
      chk(16'({line_oe, line_out}), 16'h000a);
      rchk(alarm_pkg::ADDR_STATUS, 16'h0100);
      HOST.write_byte(7'h28, 8'h15);
      settle;
      chk(16'({line_oe, line_out}), 16'h0008);
      HOST.write_byte(7'h28, 8'h16);
      settle;
      chk(16'({line_oe, line_out}), 16'h0005);
      HOST.write_byte(7'h28, 8'h11);
      settle;
      chk(16'(line_oe), 16'h0000);
      // shared line two claimed by the other functions; both claims win over the alarm output there
      HOST.write_byte(7'h28, 8'h17);
      @(posedge core_clk) rdy_req[1] <= '{owns: 1'b1, drive: 1'b1, level: 1'b0};
      settle;
      chk(16'({line_oe, line_out}), 16'h0008);
      @(posedge core_clk) gpio_req[1] <= '{owns: 1'b1, drive: 1'b1, level: 1'b1};
      settle;
      chk(16'({line_oe, line_out}), 16'h000a);
      @(posedge core_clk) gpio_req[1] <= '{owns: 1'b1, drive: 1'b0, level: 1'b0};
      settle;
      chk(16'(line_oe), 16'h0000);
      @(posedge core_clk) gpio_req <= '0;
      rdy_req <= '0;
      // direction, arming and native signed codes
      HOST.write_byte(7'h21, 8'h01);
      tick1;
      chk(16'(alarm_active), 16'h0000);
      HOST.write_byte(7'h21, 8'h81);
      HOST.write_byte(7'h28, 8'h07);
      tick1;
      chk(16'({alarm_active, cap_trig}), 16'h0002);
      // clear strobe and tick meet at one edge: the live alarm must keep its flag
      fork
         HOST.write_byte(7'h3e, 8'h10);
         tick1;
      join
      rchk(alarm_pkg::ADDR_STATUS, 16'h0100);
      @(posedge core_clk) chan <= mk(4'h2, 14'h3f00);
      tick1;
      chk(16'(alarm_active), 16'h0000);
      // every source code on alarm two and capture buffer two
      HOST.write_byte(7'h23, 8'h80);
      HOST.write_byte(7'h22, 8'h32);
      HOST.write_byte(7'h28, 8'h40);
      foreach (codes[i]) begin
         HOST.write_byte(7'h29, {codes[i], 4'h0});
         HOST.write_byte(7'h39, {codes[i], 4'h2});
         @(posedge core_clk) chan <= mk(codes[i], 14'd100);
         tick1;
         chk(16'({alarm_active, cap_trig}), (i < 6) ? 16'h0005 : 16'h0000);
         if (i < 6) begin
            chk(16'(cap_two), 16'd100);
            chk(16'(cap_one), (codes[i] == 4'h2) ? 16'd100 : 16'd0);
         end
      end
      rchk(alarm_pkg::ADDR_STATUS, 16'h0300);
      end_of_test;
   end

   initial begin
      #500000;
      fails++;
      end_of_test;
   end
endmodule // status_alarm_monitor_bench
